// file: common/relay_spi_pkg.sv
// Package: frame layout, register addresses and timing for the relay switch serial link
package relay_spi_pkg;
    // ************************************************************
    // Frame layout
    // ************************************************************
    localparam int FRAME_BITS = 8;
    localparam int CMD_WRITE_BIT = 7;
    localparam int ADDR_HI = 6;
    localparam int ADDR_LO = 4;
    localparam int STDDIAG_BIT = 1;
    localparam int BANK_SELECT_BIT = 0;
    // ************************************************************
    // Control bank addresses
    // ************************************************************
    localparam logic [2:0] ADDR_DIAGNOSIS_BANK_CURRENT_ENABLE_LOW = 3'h4;
    localparam logic [2:0] ADDR_DIAGNOSIS_BANK_CURRENT_ENABLE_HIGH = 3'h5;
    localparam logic [2:0] ADDR_COMMAND = 3'h6;
    localparam logic [2:0] ADDR_UNUSED = 3'h7;
    localparam int CMD_CLEAR_LATCHED_BIT = 0;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [7:0] TX_RESET = 8'h00;
    // ************************************************************
    // Host register port
    // ************************************************************
    localparam logic [1:0] HREG_CMD = 2'h0;
    localparam logic [1:0] HREG_STATUS = 2'h1;
    localparam logic [1:0] HREG_RXDATA = 2'h2;
    localparam logic [1:0] HREG_DIV = 2'h3;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_DONE_BIT = 1;
    // Serial clock half period in mclk cycles; 4 gives 320 ns period at 25 MHz
    localparam logic [7:0] HALF_PERIOD_RESET = 8'h04;
    localparam int MIN_SCLK_PERIOD_NS = 200;
    localparam int MCLK_PERIOD_NS = 40;
    localparam int MIN_HALF_CYCLES = (MIN_SCLK_PERIOD_NS / 2 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
endpackage : relay_spi_pkg

// file: common/relay_spi_if.sv
// Interface: four-wire serial link between host and relay switch
`timescale 1ns/100ps
`default_nettype none
interface relay_spi_if;
    logic master_chip_select_n;
    logic sclk;
    logic master_serial_out;
    logic so_o;
    logic so_oe;
    logic master_serial_in;
    // Tristate output reads low when released
    assign master_serial_in = so_oe ? so_o : 1'b0;
    modport host (output master_chip_select_n, output sclk, output master_serial_out, input master_serial_in);
    modport device (input master_chip_select_n, input sclk, input master_serial_out, output so_o, output so_oe);
endinterface : relay_spi_if
`default_nettype wire

// file: logic/sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
    parameter logic INIT = 1'b0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Data
    input wire logic din,
    output logic dout
);
    logic meta_q;
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_q <= INIT;
            dout <= INIT;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : sync2
`default_nettype wire

// file: logic/relay_spi_device.sv
// Device end: serial slave with control and diagnosis register banks
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Chip select high: ignore clock, release output
// - Sample on falling, drive on rising
// - Eight-bit frames, MSB first
// - Output MSB first, released until select
// - Load diagnosis response at select fall
// - Before first rise: error flag OR input
// - Decode only on nonzero multiple of eight
// - Valid end copies shift register to input
// - Host keeps clock low at select changes
// - Host ends each access raising select
// - Acts as eight-bit daisy chain stage
// - Host sends eight bits per chained device
// - Write: bit7, address 6:4, data 3:0
// - Read: bank bit0; bit1 standard diagnosis
// - Standard diagnosis: 00, awake, limp, pairs
// - Read reply comes in next frame
// - Error flag set after reset or bad frame
// - Eight control, four diagnosis 4-bit registers
// - Per-channel diagnosis current enable bits
// - Reset restores protocol and registers
// - Command bits self-clear; latched clear later
// - Bit5 awake, bit4 limp home
// - Diagnosis pair: faults bits 2,0; open 3,1
module relay_spi_device (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Serial link
    relay_spi_if.device spi,
    // Device status inputs
    input wire logic awake_flag,
    input wire logic limp_home_flag,
    input wire logic [7:0] channel_fault_bit,
    input wire logic [7:0] channel_open_load_bit,
    // Control outputs
    output logic [7:0] diagnosis_bank_current_enable_bit,
    output logic [15:0] input_ctrl,
    output logic clear_latched_flags,
    output logic reset_cmd,
    output logic standby_cmd,
    output logic wake_cmd,
    output logic [7:0] input_matrix
);
    // ************************************************************
    // Pin sampling and edge detection
    // ************************************************************
    logic cs_n_s, sclk_s, si_s;
    logic cs_n_p_q, sclk_p_q;
    sync2 #(.INIT(1'b1)) u_cs (.mclk(mclk), .rst(rst), .din(spi.master_chip_select_n), .dout(cs_n_s));
    sync2 #(.INIT(1'b0)) u_ck (.mclk(mclk), .rst(rst), .din(spi.sclk), .dout(sclk_s));
    sync2 #(.INIT(1'b0)) u_si (.mclk(mclk), .rst(rst), .din(spi.master_serial_out), .dout(si_s));
    always_ff @(posedge mclk) begin
        if (rst) begin
            cs_n_p_q <= 1'b1;
            sclk_p_q <= 1'b0;
        end else begin
            cs_n_p_q <= cs_n_s;
            sclk_p_q <= sclk_s;
        end
    end
    wire logic cs_fall = cs_n_p_q & ~cs_n_s;
    wire logic cs_rise = ~cs_n_p_q & cs_n_s;
    wire logic active = ~cs_n_s & ~cs_n_p_q;
    wire logic sck_fall = active & sclk_p_q & ~sclk_s;
    wire logic sck_rise = active & ~sclk_p_q & sclk_s;
    // ************************************************************
    // Registers
    // ************************************************************
    logic [3:0] ctrl_q [0:7];
    logic [7:0] shift_q;
    logic out_q;
    logic seen_rise_q;
    logic [2:0] bit_cnt_q;
    logic any_clk_q;
    logic ter_q;
    logic [7:0] reply_q;
    logic reply_valid_q;
    logic cpl_pending_q;
    logic [3:0] diagnosis_bank_bank [0:3];
    logic [7:0] std_diagnosis_bank;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            diagnosis_bank_bank[i] = {channel_open_load_bit[2*i+1], channel_fault_bit[2*i+1],
                            channel_open_load_bit[2*i], channel_fault_bit[2*i]};
        end
        std_diagnosis_bank = {2'b00, awake_flag, limp_home_flag,
                    |diagnosis_bank_bank[3], |diagnosis_bank_bank[2], |diagnosis_bank_bank[1], |diagnosis_bank_bank[0]};
    end
    // ************************************************************
    // Shift register, bit counter and serial output
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            shift_q <= relay_spi_pkg::TX_RESET;
            out_q <= 1'b0;
            seen_rise_q <= 1'b0;
            bit_cnt_q <= 3'h0;
            any_clk_q <= 1'b0;
        end else if (cs_fall) begin
            shift_q <= reply_valid_q ? reply_q : std_diagnosis_bank;
            seen_rise_q <= 1'b0;
            bit_cnt_q <= 3'h0;
            any_clk_q <= 1'b0;
        end else begin
            if (sck_rise) begin
                out_q <= shift_q[7];
                seen_rise_q <= 1'b1;
            end
            if (sck_fall) begin
                shift_q <= {shift_q[6:0], si_s};
                bit_cnt_q <= bit_cnt_q + 3'h1;
                any_clk_q <= 1'b1;
            end
        end
    end
    assign spi.so_oe = ~cs_n_s;
    assign spi.so_o = seen_rise_q ? out_q : (ter_q | si_s);
    // ************************************************************
    // Frame end: check, decode, execute
    // ************************************************************
    wire logic frame_ok = cs_rise & any_clk_q & (bit_cnt_q == 3'h0);
    wire logic [2:0] addr = shift_q[relay_spi_pkg::ADDR_HI:relay_spi_pkg::ADDR_LO];
    wire logic is_write = shift_q[relay_spi_pkg::CMD_WRITE_BIT];
    always_ff @(posedge mclk) begin
        if (rst) begin
            ter_q <= 1'b1;
        end else if (cs_rise) begin
            ter_q <= ~frame_ok;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            input_matrix <= 8'h00;
        end else if (frame_ok) begin
            input_matrix <= shift_q;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            reply_q <= relay_spi_pkg::TX_RESET;
            reply_valid_q <= 1'b0;
        end else if (frame_ok) begin
            reply_valid_q <= ~is_write & ~shift_q[relay_spi_pkg::STDDIAG_BIT];
            if (shift_q[relay_spi_pkg::BANK_SELECT_BIT]) begin
                reply_q <= {2'b01, addr[1:0], diagnosis_bank_bank[addr[1:0]]};
            end else begin
                reply_q <= {1'b1, addr, ctrl_q[addr]};
            end
        end
    end
    // Command bits 3:1 never persist; the strobes last one mclk cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                ctrl_q[i] <= relay_spi_pkg::CTRL_RESET;
            end
            reset_cmd <= 1'b0;
            standby_cmd <= 1'b0;
            wake_cmd <= 1'b0;
        end else begin
            reset_cmd <= 1'b0;
            standby_cmd <= 1'b0;
            wake_cmd <= 1'b0;
            if (frame_ok && is_write) begin
                if (addr == relay_spi_pkg::ADDR_COMMAND) begin
                    reset_cmd <= shift_q[1];
                    standby_cmd <= shift_q[2];
                    wake_cmd <= shift_q[3];
                end else if (addr != relay_spi_pkg::ADDR_UNUSED) begin
                    ctrl_q[addr] <= shift_q[3:0];
                end
            end
            if (reset_cmd || standby_cmd) begin
                for (int i = 0; i < 8; i++) begin
                    ctrl_q[i] <= relay_spi_pkg::CTRL_RESET;
                end
            end
        end
    end
    // Latched-flag clear holds until the following valid frame
    always_ff @(posedge mclk) begin
        if (rst) begin
            cpl_pending_q <= 1'b0;
        end else if (frame_ok) begin
            cpl_pending_q <= is_write && addr == relay_spi_pkg::ADDR_COMMAND
                             && shift_q[relay_spi_pkg::CMD_CLEAR_LATCHED_BIT];
        end
    end
    assign clear_latched_flags = cpl_pending_q;
    assign diagnosis_bank_current_enable_bit = {ctrl_q[relay_spi_pkg::ADDR_DIAGNOSIS_BANK_CURRENT_ENABLE_HIGH],
                                      ctrl_q[relay_spi_pkg::ADDR_DIAGNOSIS_BANK_CURRENT_ENABLE_LOW]};
    assign input_ctrl = {ctrl_q[3], ctrl_q[2], ctrl_q[1], ctrl_q[0]};
endmodule : relay_spi_device
`default_nettype wire

// file: logic/relay_spi_host.sv
// Host end: serial master driven from a small register port
`timescale 1ns/100ps
`default_nettype none
module relay_spi_host #(
    parameter int MAX_FRAMES = 3
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Serial link
    relay_spi_if.host spi
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_LOW = 4'b0010,
        S_HIGH = 4'b0100,
        S_END = 4'b1000
    } state_t;
    state_t state_q;
    logic [7:0] half_q, div_cnt_q;
    logic [23:0] tx_q, rx_q;
    logic [5:0] bits_q;
    logic done_q, cs_n_q, sclk_q;
    logic lead_q;
    logic mi_s;
    sync2 #(.INIT(1'b0)) u_mi (.mclk(mclk), .rst(rst), .din(spi.master_serial_in), .dout(mi_s));
    wire logic tick = (div_cnt_q == 8'h00);
    // wdata[23:0] frame(s) MSB first, wdata[29:24] bit count (8 per chained device)
    wire logic start = wr && addr == relay_spi_pkg::HREG_CMD && state_q == S_IDLE;
    // ************************************************************
    // Divider
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            half_q <= relay_spi_pkg::HALF_PERIOD_RESET;
        end else if (wr && addr == relay_spi_pkg::HREG_DIV && wdata[7:0] >= 8'(relay_spi_pkg::MIN_HALF_CYCLES)) begin
            half_q <= wdata[7:0];
        end
    end
    always_ff @(posedge mclk) begin
        if (rst || start || tick) begin
            div_cnt_q <= rst ? relay_spi_pkg::HALF_PERIOD_RESET - 8'h01 : half_q - 8'h01;
        end else begin
            div_cnt_q <= div_cnt_q - 8'h01;
        end
    end
    // ************************************************************
    // Frame sequencer: clock low at every select change
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= S_IDLE;
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            tx_q <= 24'h000000;
            rx_q <= 24'h000000;
            bits_q <= 6'h00;
            done_q <= 1'b0;
            lead_q <= 1'b0;
        end else begin
            if (rd && addr == relay_spi_pkg::HREG_STATUS) begin
                done_q <= 1'b0;
            end
            case (state_q)
                S_IDLE: begin
                    if (start) begin
                        tx_q <= wdata[23:0] << (6'd24 - wdata[29:24]);
                        bits_q <= (wdata[29:24] == 6'h00 || wdata[29:24] > 6'(8 * MAX_FRAMES)) ? 6'h08 : wdata[29:24];
                        cs_n_q <= 1'b0;
                        lead_q <= 1'b1;
                        state_q <= S_LOW;
                    end
                end
                S_LOW: if (tick) begin
                    // Data moves with the rising clock, so the far end's falling-edge sample finds it settled;
                    // the returned bit is taken a whole low phase late, as both synchronisers outlast a short half
                    if (!lead_q) begin
                        rx_q <= {rx_q[22:0], mi_s};
                        tx_q <= {tx_q[22:0], 1'b0};
                    end
                    lead_q <= 1'b0;
                    sclk_q <= 1'b1;
                    state_q <= S_HIGH;
                end
                S_HIGH: if (tick) begin
                    sclk_q <= 1'b0;
                    bits_q <= bits_q - 6'h01;
                    state_q <= (bits_q == 6'h01) ? S_END : S_LOW;
                end
                S_END: if (tick) begin
                    rx_q <= {rx_q[22:0], mi_s};
                    cs_n_q <= 1'b1;
                    done_q <= 1'b1;
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
    assign spi.master_chip_select_n = cs_n_q;
    assign spi.sclk = sclk_q;
    assign spi.master_serial_out = tx_q[23];
    // ************************************************************
    // Read port
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            case (addr)
                relay_spi_pkg::HREG_STATUS: rdata <= {30'h0, done_q, state_q != S_IDLE};
                relay_spi_pkg::HREG_RXDATA: rdata <= {8'h00, rx_q};
                relay_spi_pkg::HREG_DIV: rdata <= {24'h0, half_q};
                default: rdata <= 32'h00000000;
            endcase
        end
    end
endmodule : relay_spi_host
`default_nettype wire

// file: tb/relay_spi_properties.sv
// Checker: timing relations on the serial link between host and device ends
`timescale 1ns/100ps
`default_nettype none
module relay_spi_properties (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Serial link
    input wire logic master_chip_select_n,
    input wire logic sclk,
    input wire logic master_serial_out,
    input wire logic so_o,
    input wire logic so_oe,
    input wire logic master_serial_in
);
    // ****
    // Frame tracking
    // ****
    logic sclk_q;
    logic rose_q;
    logic ter_q;
    logic [5:0] cnt_q;
    logic [4:0] pre_q;
    logic [3:0] since_q;
    wire logic sclk_up = sclk && !sclk_q;
    always_ff @(posedge mclk) begin
        sclk_q <= sclk;
        if (rst || master_chip_select_n) begin
            rose_q <= 1'b0;
            pre_q <= 5'h0;
        end else begin
            rose_q <= rose_q || sclk_up;
            pre_q <= (pre_q == 5'h1f) ? pre_q : pre_q + 5'h1;
        end
    end
    // Error flag mirror; a frame with no clock at all leaves it alone, the host never sends one
    always_ff @(posedge mclk) begin
        if (rst) begin
            ter_q <= 1'b1;
            cnt_q <= 6'h0;
        end else if (master_chip_select_n) begin
            ter_q <= (cnt_q == 6'h0) ? ter_q : (cnt_q[2:0] != 3'h0);
            cnt_q <= 6'h0;
        end else if (sclk_up) begin
            cnt_q <= cnt_q + 6'h1;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst || sclk_up)
            since_q <= 4'h0;
        else if (since_q != 4'hf)
            since_q <= since_q + 4'h1;
    end
    // ****
    // Properties
    // ****
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_release;
        master_chip_select_n [*5] |-> !so_oe;
    endproperty
    a_release: assert property (p_release) else $error("output driven while deselected");
    property p_select;
        $fell(master_chip_select_n) |-> ##[1:5] so_oe;
    endproperty
    a_select: assert property (p_select) else $error("output not driven after select");
    property p_edge_low;
        $changed(master_chip_select_n) |-> !sclk;
    endproperty
    a_edge_low: assert property (p_edge_low) else $error("clock high at select change");
    property p_idle_low;
        master_chip_select_n |-> !sclk;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("clock runs while deselected");
    property p_lead_low;
        $fell(master_chip_select_n) |-> !sclk [*3];
    endproperty
    a_lead_low: assert property (p_lead_low) else $error("clock rises too soon after select");
    property p_clk_high;
        $rose(sclk) |-> sclk [*3];
    endproperty
    a_clk_high: assert property (p_clk_high) else $error("clock high phase too short");
    property p_preamble;
        !master_chip_select_n && !rose_q && pre_q >= 5'ha && !sclk |-> master_serial_in == (ter_q | master_serial_out);
    endproperty
    a_preamble: assert property (p_preamble) else $error("error flag level wrong before first clock");
    property p_shift;
        !master_chip_select_n && rose_q && $changed(so_o) |-> since_q <= 4'h6;
    endproperty
    a_shift: assert property (p_shift) else $error("output changed away from a rising clock");
endmodule : relay_spi_properties
`default_nettype wire

// file: tb/relay_switch_spi_register_access_bench.sv
// Bench: host and device ends joined over the serial link, driven through the host register port
`timescale 1ns/100ps
`default_nettype none
module relay_switch_spi_register_access_bench;
    // ****
    // Signals and ends
    // ****
    logic mclk;
    logic rst;
    logic [1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic awake;
    logic limp;
    logic [7:0] fault;
    logic [7:0] open_load;
    logic [7:0] dce;
    logic [15:0] ictrl;
    logic clr;
    logic [7:0] imatrix;
    logic rcmd;
    logic scmd;
    logic wcmd;
    logic [2:0] seen_cmd;
    logic [31:0] rx;
    int fails;
    int comparisons;
    relay_spi_if spi_link();
    relay_spi_host u_relay_spi_host (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .spi(spi_link));
    relay_spi_device u_relay_spi_device (.mclk(mclk), .rst(rst), .spi(spi_link), .awake_flag(awake),
        .limp_home_flag(limp), .channel_fault_bit(fault), .channel_open_load_bit(open_load),
        .diagnosis_bank_current_enable_bit(dce), .input_ctrl(ictrl), .clear_latched_flags(clr), .reset_cmd(rcmd),
        .standby_cmd(scmd), .wake_cmd(wcmd), .input_matrix(imatrix));
    relay_spi_properties u_relay_spi_properties (.mclk(mclk), .rst(rst),
        .master_chip_select_n(spi_link.master_chip_select_n), .sclk(spi_link.sclk),
        .master_serial_out(spi_link.master_serial_out), .so_o(spi_link.so_o), .so_oe(spi_link.so_oe),
        .master_serial_in(spi_link.master_serial_in));
    // Sticky record of the one-cycle command strobes, which are too short to poll
    always @(posedge mclk) begin
        if (rst)
            seen_cmd <= 3'h0;
        else
            seen_cmd <= seen_cmd | {wcmd, scmd, rcmd};
    end
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic reg_wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [1:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask : reg_rd
    task automatic set_div(input logic [31:0] d);
        reg_wr(relay_spi_pkg::HREG_DIV, d);
    endtask : set_div
    // A negative pre skips the look at the link before the first clock
    task automatic xfer(input int n, input logic [23:0] bits, input int pre);
        logic [31:0] st;
        reg_wr(relay_spi_pkg::HREG_CMD, {2'h0, 6'(n), bits});
        if (pre >= 0) begin
            repeat (12) @(posedge mclk);
            @(negedge mclk);
            chk(32'(spi_link.master_serial_in), 32'(pre));
        end
        st = 32'h0;
        for (int i = 0; i < 400 && st[relay_spi_pkg::STATUS_DONE_BIT] !== 1'b1; i++)
            reg_rd(relay_spi_pkg::HREG_STATUS, st);
        chk(32'(st[relay_spi_pkg::STATUS_DONE_BIT]), 32'h1);
        reg_rd(relay_spi_pkg::HREG_RXDATA, rx);
        // Let the device finish decoding and any strobe-driven clear before outputs are compared
        repeat (2) @(posedge mclk);
    endtask : xfer
    task automatic test_done();
        if (fails == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    // ****
    // Clock, watchdog and tests
    // ****
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        repeat (40000) @(posedge mclk);
        fails++;
        test_done();
    end
    initial begin
        fails = 0;
        comparisons = 0;
        rst = 1'b1;
        addr = 2'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        awake = 1'b1;
        limp = 1'b0;
        fault = 8'h10;
        open_load = 8'h01;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        // Wide half period so the level before the first clock can settle through the synchronisers
        set_div(32'h14);
        xfer(8, 24'h02, 1);
        chk(32'(rx[7:0]), 32'h25);
        set_div(32'h4);
        xfer(8, 24'hc5, -1);
        chk(32'(imatrix), 32'hc5);
        xfer(8, 24'hda, -1);
        chk(32'(dce), 32'ha5);
        xfer(8, 24'h50, -1);
        xfer(8, 24'h21, -1);
        chk(32'(rx[7:0]), 32'hda);
        xfer(8, 24'h02, -1);
        chk(32'(rx[7:0]), 32'h61);
        xfer(8, 24'h02, -1);
        chk(32'(rx[7:0]), 32'h25);
        xfer(5, 24'h1f, -1);
        chk(32'(dce), 32'ha5);
        set_div(32'h14);
        xfer(8, 24'h02, 1);
        xfer(8, 24'h02, 0);
        set_div(32'h4);
        xfer(16, 24'h3cc9, -1);
        chk(32'(rx[15:0]), 32'h253c);
        chk(32'(dce), 32'ha9);
        xfer(8, 24'h83, -1);
        chk(32'(ictrl), 32'h3);
        xfer(8, 24'he1, -1);
        chk(32'(clr), 32'h1);
        xfer(8, 24'h02, -1);
        chk(32'(clr), 32'h0);
        xfer(8, 24'he2, -1);
        chk(32'(dce), 32'h0);
        chk(32'(ictrl), 32'h0);
        chk(32'(seen_cmd), 32'h1);
        xfer(8, 24'hec, -1);
        chk(32'(seen_cmd), 32'h7);
        xfer(8, 24'hcf, -1);
        chk(32'(dce), 32'hf);
        // Reset in mid-run with new status levels
        @(posedge mclk);
        rst <= 1'b1;
        awake <= 1'b0;
        limp <= 1'b1;
        fault <= 8'h80;
        open_load <= 8'h04;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk(32'(dce), 32'h0);
        set_div(32'h14);
        xfer(8, 24'h02, 1);
        chk(32'(rx[7:0]), 32'h1a);
        test_done();
    end
endmodule : relay_switch_spi_register_access_bench
`default_nettype wire
